// >>> bench/sbp2_command_agent_config_tb_top.sv
// self-checking bench for the command agent register bank
`timescale 1ns/1ps
module sbp2_command_agent_config_tb_top;
  import sca_pkg::*;
  logic clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0, bus_reset = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, base;
  logic host_tx_valid = 0, fetch_pointer_wr = 0, bus_hit, bus_wr_valid;
  logic [5:0] host_tx_label = 0;
  logic [1:0] fetch_pointer_agent = 0, bus_hit_agent;
  logic [47:0] fetch_pointer_data = 0, bus_wr_addr;
  logic [47:0] ptr [4];
  logic [4:0] bus_hit_offset, off;
  logic [3:0] unsolicited_status_allowed, bus_id_valid, msk;
  logic [63:0] assigned_bus_id, ids;
  int num_errors = 0, n_compared = 0;
  sca_regs dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bus_reset(bus_reset),
    .bus_wr_valid(bus_wr_valid), .bus_wr_addr(bus_wr_addr),
    .host_tx_valid(host_tx_valid), .host_tx_label(host_tx_label),
    .fetch_pointer_wr(fetch_pointer_wr),
    .fetch_pointer_agent(fetch_pointer_agent),
    .fetch_pointer_data(fetch_pointer_data), .bus_hit(bus_hit),
    .bus_hit_agent(bus_hit_agent), .bus_hit_offset(bus_hit_offset),
    .unsolicited_status_allowed(unsolicited_status_allowed),
    .bus_id_valid(bus_id_valid), .assigned_bus_id(assigned_bus_id));
  sca_initiator_model ini (.clk_sys(clk_sys), .bus_wr_valid(bus_wr_valid),
    .bus_wr_addr(bus_wr_addr));
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(64'(reg_rdata), 64'(e));
  endtask
  task automatic pulse_bus_reset;
    @(posedge clk_sys);
    bus_reset <= 1'b1;
    @(posedge clk_sys);
    bus_reset <= 1'b0;
  endtask
  // control word: select, flags {autoclear,valid,0,wr id,rd id}, id
  function automatic logic [31:0] ctl(int s, logic [4:0] f,
    logic [15:0] id);
    return {2'(s), 9'h0, f, id};
  endfunction
  function automatic logic [47:0] wa(int a, logic [4:0] o);
    return WIN_ORIGIN + 48'(base[23:0]) * 4 + 48'(a * 32) + 48'(o);
  endfunction
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h97280db8));
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(OFF_BASE, RST_BASE);
    rd(OFF_CTRL, RST_CTRL);
    rd(OFF_PTR_HI, 32'h0);
    rd(8'h60, 32'h0);
    ids = {4{RST_BUS_ID}};
    chk(assigned_bus_id, ids);
    base = (32'h4000 + $urandom % 32'hffbffd) & 32'h00ff_fffc;
    wr(OFF_BASE, base);
    pulse_bus_reset();
    rd(OFF_BASE, base);
    for (int a = 0; a < 4; a++)
    begin
      ptr[a] = 48'({$urandom, $urandom});
      @(posedge clk_sys);
      fetch_pointer_wr <= 1'b1;
      fetch_pointer_agent <= 2'(a);
      fetch_pointer_data <= ptr[a];
      @(posedge clk_sys);
      fetch_pointer_wr <= 1'b0;
      fetch_pointer_data <= ~ptr[a];
    end
    for (int a = 0; a < 4; a++)
    begin
      ids[16*a +: 16] = 16'($urandom);
      wr(OFF_CTRL, ctl(a, 5'h02, ids[16*a +: 16]));
      cyc(2);
      chk(assigned_bus_id, ids);
      wr(OFF_CTRL, ctl(a, 5'h08, 16'h0));
      cyc(2);
      chk(64'(bus_id_valid[a]), 64'h1);
      wr(OFF_CTRL, ctl(a, 5'h09, 16'h0));
      cyc(2);
      rd(OFF_CTRL, ctl(a, 5'h09, ids[16*a +: 16]));
      rd(OFF_CTRL, ctl(a, 5'h08, ids[16*a +: 16]));
      rd(OFF_PTR_HI, {16'h0, ptr[a][47:32]});
      rd(OFF_PTR_LO, ptr[a][31:0]);
    end
    pulse_bus_reset();
    cyc(1);
    chk(64'(bus_id_valid), 64'h0);
    chk(assigned_bus_id, ids);
    rd(OFF_CTRL, ctl(3, 5'h00, ids[63:48]));
    rd(OFF_PTR_HI, {16'h0, ptr[3][47:32]});
    for (int a = 0; a < 4; a++)
    begin
      off = {3'($urandom % 8), 2'b00};
      ini.send(wa(a, off), $urandom % 3);
      #1 chk(64'({bus_hit, bus_hit_agent, bus_hit_offset}),
        64'({1'b1, 2'(a), off}));
      ini.send(wa(a, OFF_UNSOL_EN), 0);
      #1 chk(64'(unsolicited_status_allowed[a]), 64'h1);
    end
    ini.send(wa(4, 5'h0), 1);
    #1 chk(64'(bus_hit), 64'h0);
    ini.send(wa(0, 5'h0) - 48'h4, 0);
    #1 chk(64'(bus_hit), 64'h0);
    msk = 4'hf;
    for (int e = 0; e < 2; e++)
    begin
      wr(OFF_CTRL, ctl(0, {e[0], 4'h0}, 16'h0));
      for (int a = 0; a < 4; a++)
      begin
        @(posedge clk_sys);
        host_tx_valid <= 1'b1;
        host_tx_label <= {LABEL_TAG, 2'(a), 1'($urandom)};
        @(posedge clk_sys);
        host_tx_valid <= 1'b0;
        host_tx_label <= ~host_tx_label;
        #1;
        if (e == 1)
          msk[a] = 1'b0;
        chk(64'(unsolicited_status_allowed), 64'(msk));
      end
    end
    tally_and_finish();
  end
endmodule

// >>> bench/sca_initiator_model.sv
// bus-side initiator issuing quadlet write requests into agent windows
`timescale 1ns/1ps
module sca_initiator_model (
  input wire logic clk_sys,
  output logic bus_wr_valid = 1'b0,
  output logic [47:0] bus_wr_addr = 48'h0
);
  // one quadlet write after a gap; address scrambled once released
  task automatic send(input logic [47:0] a, input int gap);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    bus_wr_valid <= 1'b1;
    bus_wr_addr <= a;
    @(posedge clk_sys);
    bus_wr_valid <= 1'b0;
    bus_wr_addr <= ~a;
  endtask
endmodule

// >>> hw/sca_pkg.sv
// constants for the command agent configuration register bank
package sca_pkg;
  localparam int AGENTS = 4;
  localparam int AW = 8;
  localparam int BUS_AW = 48;
  // register byte offsets
  localparam logic [7:0] OFF_BASE = 8'h4c;
  localparam logic [7:0] OFF_CTRL = 8'h50;
  localparam logic [7:0] OFF_PTR_HI = 8'h54;
  localparam logic [7:0] OFF_PTR_LO = 8'h58;
  // reset values
  localparam logic [31:0] RST_BASE = 32'h0000_0000;
  localparam logic [31:0] RST_CTRL = 32'h0000_ffff;
  localparam logic [47:0] RST_PTR = 48'h0000_0000_0000;
  localparam logic [15:0] RST_BUS_ID = 16'hffff;
  // field positions (quadlet bit 0 is the msb, so 1394 bit n is sv 31-n)
  localparam int BASE_MSB = 23;
  localparam int BASE_W = 24;
  localparam int SEL_MSB = 31;
  localparam int SEL_LSB = 30;
  localparam int AUTOCLR_BIT = 20;
  localparam int VALID_BIT = 19;
  localparam int WR_ID_BIT = 17;
  localparam int RD_ID_BIT = 16;
  localparam int ID_MSB = 15;
  // bus window layout
  localparam logic [47:0] WIN_ORIGIN = 48'hffff_f000_0000;
  localparam logic [47:0] WIN_STRIDE = 48'h0000_0000_0020;
  localparam logic [47:0] WIN_SPAN = 48'h0000_0000_0080;
  localparam logic [4:0] OFF_UNSOL_EN = 5'h14;
  // transaction label pattern for automatic clearing
  localparam logic [2:0] LABEL_TAG = 3'b111;
endpackage

// >>> hw/sca_regs.sv
// command agent window, node id control and pointer view registers
// Notes on behaviour
// - agent 0 window at origin plus base times four
// - agents 1 to 3 follow at 20h steps
// - base register resets zero, survives bus reset
// - control resets 0000ffffh, bus reset only clears valid
// - agent select picks pointer shown in views
// - agent select names agent for id operations
// - enabled tagged host packet clears unsolicited enable
// - disabled: tagged packets leave unsolicited enable alone
// - valid bit sets selected agent valid, bus reset clears
// - write id bit copies id, then self clears
// - read id bit loads id, clears after read
// - node id field resets ffffh, survives bus reset
// - high view returns selected pointer high part
// - high view resets zero, bus reset leaves it
// - bus write to enable register sets variable
// - low view returns selected pointer low word
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module sca_regs
  import sca_pkg::*;
#(
  parameter int N_AGENTS = sca_pkg::AGENTS
)(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [sca_pkg::AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic bus_reset,
  input wire logic bus_wr_valid,
  input wire logic [sca_pkg::BUS_AW-1:0] bus_wr_addr,
  input wire logic host_tx_valid,
  input wire logic [5:0] host_tx_label,
  input wire logic fetch_pointer_wr,
  input wire logic [1:0] fetch_pointer_agent,
  input wire logic [47:0] fetch_pointer_data,
  output logic bus_hit,
  output logic [1:0] bus_hit_agent,
  output logic [4:0] bus_hit_offset,
  output logic [N_AGENTS-1:0] unsolicited_status_allowed,
  output logic [N_AGENTS-1:0] bus_id_valid,
  output logic [16*N_AGENTS-1:0] assigned_bus_id
);
  import sca_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // host register state
  logic [BASE_W-1:0] base_q;
  logic [1:0] agent_select_q;
  logic label_autoclear_en_q;
  logic bus_id_write_strobe_q;
  logic bus_id_read_strobe_q;
  logic rd_load_q;
  logic [15:0] id_field_q;
  logic [47:0] agent_base_q;
  logic [47:0] fetch_pointer_q [N_AGENTS];
  logic [15:0] id_store_q [N_AGENTS];
  logic [N_AGENTS-1:0] valid_q;
  logic [N_AGENTS-1:0] unsol_q;
  logic wr_base;
  logic wr_ctrl;
  logic rd_ctrl;
  logic [47:0] sel_ptr;

  assign wr_base = reg_wr && (reg_addr == OFF_BASE);
  assign wr_ctrl = reg_wr && (reg_addr == OFF_CTRL);
  assign rd_ctrl = reg_rd && (reg_addr == OFF_CTRL);
  assign sel_ptr = fetch_pointer_q[agent_select_q];

  // base offset register, untouched by bus reset
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      base_q <= RST_BASE[BASE_MSB:0];
    else if (wr_base)
      base_q <= reg_wdata[BASE_MSB:0];
  end

  // agent 0 window start, host keeps base aligned and above the floor
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      agent_base_q <= WIN_ORIGIN;
    else
      agent_base_q <= WIN_ORIGIN + {22'h0, base_q, 2'b00};
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register fields
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      agent_select_q <= RST_CTRL[SEL_MSB:SEL_LSB];
      label_autoclear_en_q <= RST_CTRL[AUTOCLR_BIT];
    end
    else if (wr_ctrl)
    begin
      agent_select_q <= reg_wdata[SEL_MSB:SEL_LSB];
      label_autoclear_en_q <= reg_wdata[AUTOCLR_BIT];
    end
  end

  // write id strobe lasts one cycle, then clears itself
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      bus_id_write_strobe_q <= RST_CTRL[WR_ID_BIT];
    else
      bus_id_write_strobe_q <= wr_ctrl && reg_wdata[WR_ID_BIT];
  end

  // read id: load pulse next cycle, bit stands until a control read
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      rd_load_q <= 1'b0;
      bus_id_read_strobe_q <= RST_CTRL[RD_ID_BIT];
    end
    else
    begin
      rd_load_q <= wr_ctrl && reg_wdata[RD_ID_BIT];
      if (wr_ctrl && reg_wdata[RD_ID_BIT])
        bus_id_read_strobe_q <= 1'b1;
      else if (rd_ctrl)
        bus_id_read_strobe_q <= 1'b0;
    end
  end

  // node id field, kept through bus reset
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      id_field_q <= RST_CTRL[ID_MSB:0];
    else if (rd_load_q)
      id_field_q <= id_store_q[agent_select_q];
    else if (wr_ctrl)
      id_field_q <= reg_wdata[ID_MSB:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // per agent node id, valid, pointer and unsolicited enable
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < N_AGENTS; i++)
        id_store_q[i] <= RST_BUS_ID;
    end
    else if (bus_id_write_strobe_q)
      id_store_q[agent_select_q] <= id_field_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      valid_q <= '0;
    else if (bus_reset)
      valid_q <= '0;
    else if (wr_ctrl && reg_wdata[VALID_BIT])
      valid_q[reg_wdata[SEL_MSB:SEL_LSB]] <= 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < N_AGENTS; i++)
        fetch_pointer_q[i] <= RST_PTR;
    end
    else if (fetch_pointer_wr)
      fetch_pointer_q[fetch_pointer_agent] <= fetch_pointer_data;
  end

  // bus window decode
  logic [47:0] bus_rel;
  logic bus_in_win;
  logic use_set;
  logic [1:0] use_agent;
  logic label_clr;
  logic [1:0] label_agent;
  assign bus_rel = bus_wr_addr - agent_base_q;
  assign bus_in_win = bus_wr_valid && (bus_wr_addr >= agent_base_q)
    && (bus_rel < WIN_SPAN);
  assign use_agent = bus_rel[6:5];
  assign use_set = bus_in_win && (bus_rel[4:0] == OFF_UNSOL_EN);
  assign label_agent = host_tx_label[2:1];
  assign label_clr = label_autoclear_en_q && host_tx_valid
    && (host_tx_label[5:3] == LABEL_TAG);

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      bus_hit <= 1'b0;
      bus_hit_agent <= 2'b00;
      bus_hit_offset <= 5'h00;
    end
    else
    begin
      bus_hit <= bus_in_win;
      bus_hit_agent <= bus_rel[6:5];
      bus_hit_offset <= bus_rel[4:0];
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      unsol_q <= '0;
    else
    begin
      for (int i = 0; i < N_AGENTS; i++)
      begin
        if (use_set && (use_agent == i[1:0]))
          unsol_q[i] <= 1'b1;
        else if (label_clr && (label_agent == i[1:0]))
          unsol_q[i] <= 1'b0;
      end
    end
  end

  assign unsolicited_status_allowed = unsol_q;
  assign bus_id_valid = valid_q;

  always_comb
  begin
    for (int i = 0; i < N_AGENTS; i++)
      assigned_bus_id[16*i +: 16] = id_store_q[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        OFF_BASE: reg_rdata <= {8'h00, base_q};
        OFF_CTRL: reg_rdata <= {agent_select_q, 9'h000, label_autoclear_en_q,
          valid_q[agent_select_q], 1'b0, bus_id_write_strobe_q,
          bus_id_read_strobe_q, id_field_q};
        OFF_PTR_HI: reg_rdata <= {16'h0000, sel_ptr[47:32]};
        OFF_PTR_LO: reg_rdata <= sel_ptr[31:0];
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_window_base: assert property (wr_base ##2 1 |->
    agent_base_q == WIN_ORIGIN + {22'h0, $past(reg_wdata[BASE_MSB:0], 2),
    2'b00}) else $error("agent window base wrong");
  a_win_agent: assert property (bus_in_win && bus_rel[6:5] == 2'd3 |=>
    bus_hit && bus_hit_agent == 2'd3) else $error("window agent wrong");
  a_base_keep: assert property (bus_reset && !wr_base |=> $stable(base_q))
    else $error("base changed by bus reset");
  a_autoclear_on: assert property (label_clr && !use_set
    |=> !unsol_q[$past(label_agent)]) else $error("autoclear missed");
  a_autoclear_off: assert property (!label_autoclear_en_q && !use_set
    |=> unsol_q == $past(unsol_q)) else $error("unsol changed");
  a_unsol_set: assert property (use_set |=> unsol_q[$past(use_agent)])
    else $error("unsolicited enable not set");
  a_valid_clear: assert property (bus_reset |=> valid_q == '0)
    else $error("valid kept over bus reset");
  a_id_copy: assert property (wr_ctrl && reg_wdata[WR_ID_BIT] ##1 1 |=>
    id_store_q[agent_select_q] == $past(id_field_q) && !bus_id_write_strobe_q)
    else $error("node id not copied");
  a_id_load: assert property (rd_load_q && !wr_ctrl |=>
    id_field_q == $past(id_store_q[agent_select_q]))
    else $error("node id not loaded");
  a_rd_clear: assert property (rd_ctrl && !wr_ctrl |=> !bus_id_read_strobe_q)
    else $error("read id bit not cleared");
  a_hi_view: assert property (reg_rd && reg_addr == OFF_PTR_HI |=>
    reg_rdata == {16'h0000, $past(sel_ptr[47:32])})
    else $error("high view wrong");
  a_lo_view: assert property (reg_rd && reg_addr == OFF_PTR_LO |=>
    reg_rdata == $past(sel_ptr[31:0])) else $error("low view wrong");
  a_ptr_keep: assert property (bus_reset && !fetch_pointer_wr |=>
    $stable(sel_ptr) || $changed(agent_select_q))
    else $error("pointer changed by bus reset");
  a_id_survive: assert property (bus_reset && !wr_ctrl && !rd_load_q |=>
    $stable(id_field_q)) else $error("node id field lost");

  c_id_write: cover property (wr_ctrl && reg_wdata[WR_ID_BIT] ##2
    bus_id_valid != '0);
  c_autoclear: cover property (use_set ##[1:8] label_clr);
  c_set_clear: cover property (use_set && label_clr);
  c_id_read: cover property (rd_load_q ##[1:4] rd_ctrl);
endmodule
